// File: verilog/fm_pkg.sv
// Purpose: constants of the frequency monitor and I/O conditioning
// Assumes: 100 MHz clock, frequencies in units of 0.1 mHz
// Notes:   all offsets are byte addresses on the plain register port
package fm_pkg;
    // ************************************************************
    // register offsets
    // ************************************************************
    localparam logic [7:0] A_CTRL   = 8'h00;
    localparam logic [7:0] A_STAT   = 8'h04;
    localparam logic [7:0] A_MASK   = 8'h08;
    localparam logic [7:0] A_DLY    = 8'h0C;
    localparam logic [7:0] A_FMIN   = 8'h10;
    localparam logic [7:0] A_FMAX   = 8'h14;
    localparam logic [7:0] A_FACT   = 8'h18;
    localparam logic [7:0] A_IOPOL  = 8'h1C;
    localparam logic [7:0] A_OFSA   = 8'h20;
    localparam logic [7:0] A_MULA   = 8'h24;
    localparam logic [7:0] A_OFSB   = 8'h28;
    localparam logic [7:0] A_MULB   = 8'h2C;
    localparam logic [7:0] A_LOAD   = 8'h30;
    localparam logic [7:0] A_ARES   = 8'h34;
    // ************************************************************
    // field positions
    // ************************************************************
    localparam int B_CLOSED = 2;
    localparam int B_RUN    = 3;
    localparam int B_FAULT  = 0;
    localparam int B_CAPT   = 1;
    localparam int B_OINV   = 8;
    // ************************************************************
    // monitor modes
    // ************************************************************
    localparam logic [1:0] M_OFF = 2'h0;
    localparam logic [1:0] M_ON  = 2'h1;
    localparam logic [1:0] M_SET = 2'h2;
    // ************************************************************
    // reset values and timing
    // ************************************************************
    localparam logic [15:0] R_DLY_MS = 16'hEA60;      // 60000 ms
    localparam logic [31:0] R_FMIN   = 32'h0000755B;  // 3.0043 Hz
    localparam logic [31:0] R_FMAX   = 32'h002DC6C0;  // 300 Hz
    localparam logic [15:0] R_MUL    = 16'h1000;      // 1.0 in Q4.12
    localparam int CLK_NS     = 10;
    localparam int MS_NS      = 1000000;
    localparam int CYC_PER_MS = MS_NS / CLK_NS;
    localparam int MARGIN_PCT = 3;
    localparam int PCT_DIV    = 100;
    localparam int MUL_FRAC   = 12;
    localparam logic [11:0] RES_MAX = 12'hFFF;        // 100 %
endpackage

// File: verilog/fm_scale.sv
// Purpose: offset, multiply and clamp of one digitised analog input
// Assumes: 12-bit code spans 0..24 V, multiplier in Q4.12
// Notes:   result is 0..RES_MAX, meaning 0..100 %
`timescale 1ns/100ps
module fm_scale (
    // clock and reset
    input  wire logic                 i_clk,
    input  wire logic                 i_reset,
    // sample and settings
    input  wire logic [11:0]          i_code,
    input  wire logic signed [15:0]   i_ofs,
    input  wire logic [15:0]          i_mul,
    // scaled result
    output logic [11:0]               o_res
);
    import fm_pkg::*;

    typedef struct packed {
        logic [11:0] res;
    } fm_sc_t;

    fm_sc_t r;
    fm_sc_t next_r;
    logic signed [16:0] sum;
    logic signed [33:0] prod;
    logic signed [33:0] shr;

    // ************************************************************
    // scaling path
    // ************************************************************
    // RL10 offset then multiply
    assign sum  = 17'(signed'({5'h00, i_code})) + 17'(i_ofs);
    assign prod = 34'(sum) * 34'(signed'({1'b0, i_mul}));
    assign shr  = prod >>> MUL_FRAC;

    // RL11 clamp to range
    always_comb begin
        next_r = r;
        if (shr < 0) begin
            next_r.res = 12'h000;
        end else if (shr > 34'(RES_MAX)) begin
            next_r.res = RES_MAX;
        end else begin
            next_r.res = shr[11:0];
        end
    end

    // state register
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    assign o_res = r.res;

    default clocking dc @(posedge i_clk); endclocking
    default disable iff (i_reset);

    neg_clamp_a: assert property (sum <= 0 |=> o_res == 12'h000) // RL11
        else $error("negative sum not clamped to zero");
    unit_mul_a: assert property ( // RL10
        (i_mul == R_MUL && i_ofs == 16'sh0000) |=> o_res == $past(i_code))
        else $error("unit scaling does not pass code through");
endmodule // fm_scale

// File: verilog/fm_monitor.sv
// Purpose: drive frequency supervision and I/O level conditioning
// Assumes: frequency and ADC codes come from logic on i_clk
// Notes:   registers on a plain port, read data one cycle later
//
// Function
// RL1: fault only after frequency stays out of band for the delay, 60000 ms
// RL2: supervision works only in closed-loop mode, idle in open loop
// RL3: default limits 3.0043 Hz and 300 Hz, both writable
// RL4: modes off, on, set; on while stopped keeps stored limits
// RL5: set while running stores measured frequency minus and plus 3 %
// RL6: operator selects set only while the unit enable is on
// RL7: confirmed fault switches the magnet drive off and reports status
// RL8: inputs active high by default, per-input active-low option
// RL9: outputs non-inverted by default, per-output inversion option
// RL10: analog input gets signed offset first, then multiplier
// RL11: scaled result clamped to 0..100 %, 24 V range not extended
// RL12: two-choice load resistor selection per analog input
// RL13: configurator computes multiplier from spans times 0,29 V per g
// RL14: delay timer restarts when frequency returns inside the band
// RL15: monitor off never raises the frequency fault
`timescale 1ns/100ps
module fm_monitor #(
    parameter int P_CYC_PER_MS = fm_pkg::CYC_PER_MS
) (
    // clock and reset
    input  wire logic         i_clk,
    input  wire logic         i_reset,
    // register port
    input  wire logic [7:0]   i_addr,
    input  wire logic [31:0]  i_wdata,
    input  wire logic         i_wr,
    input  wire logic         i_rd,
    output logic [31:0]       o_rdata,
    // drive side
    input  wire logic [31:0]  i_freq_act,
    output logic              o_drive_en,
    output logic              o_freq_fault,
    output logic              o_irq,
    // digital pins and functions
    input  wire logic [3:0]   i_din_pin,
    output logic [3:0]        o_din_func,
    input  wire logic [3:0]   i_dout_func,
    output logic [3:0]        o_dout_pin,
    // analog inputs
    input  wire logic [11:0]  i_analog_input_a,
    input  wire logic [11:0]  i_analog_input_b,
    output logic [11:0]       o_analog_a,
    output logic [11:0]       o_analog_b,
    output logic [1:0]        o_load_sel
);
    import fm_pkg::*;

    // ************************************************************
    // state of the block
    // ************************************************************
    // registers, flags, synchronisers and counters share one struct
    // so that reset and update each happen in exactly one place
    typedef struct packed {
        logic [1:0]  mode;
        logic        closed;
        logic        run;
        logic        fault;
        logic        capt;
        logic [1:0]  mask;
        logic [15:0] dly;
        logic [31:0] fmin;
        logic [31:0] fmax;
        logic [3:0]  ipol;
        logic [3:0]  oinv;
        logic [15:0] ofs_a;
        logic [15:0] mul_a;
        logic [15:0] ofs_b;
        logic [15:0] mul_b;
        logic [1:0]  load;
        logic [3:0]  sync1;
        logic [3:0]  sync2;
        logic [3:0]  din;
        logic [3:0]  dout;
        logic [31:0] msdiv;
        logic [15:0] mscnt;
        logic [31:0] rdata;
        logic        irq;
        logic        drive;
    } fm_st_t;

    // values after reset; limits and delay start at their defaults
    localparam fm_st_t ST_RST = '{
        mode: M_OFF, closed: 1'b0, run: 1'b0, fault: 1'b0, capt: 1'b0,
        mask: 2'h0, dly: R_DLY_MS, fmin: R_FMIN, fmax: R_FMAX,
        ipol: 4'h0, oinv: 4'h0, ofs_a: 16'h0000, mul_a: R_MUL,
        ofs_b: 16'h0000, mul_b: R_MUL, load: 2'h0, sync1: 4'h0,
        sync2: 4'h0, din: 4'h0, dout: 4'h0, msdiv: 32'h00000000,
        mscnt: 16'h0000, rdata: 32'h00000000, irq: 1'b0, drive: 1'b0};

    // current state, its next value and shared combinational terms
    fm_st_t      r;
    fm_st_t      next_r;
    logic [11:0] res_a;
    logic [11:0] res_b;
    logic        oob;
    logic        active;
    logic        tick;
    logic [33:0] margin;
    logic [31:0] cap_lo;
    logic [31:0] cap_hi;
    logic        wr_ctrl;
    logic        set_req;

    // ************************************************************
    // supervision terms
    // ************************************************************
    // band edges themselves count as inside the band
    assign oob    = (i_freq_act < r.fmin) || (i_freq_act > r.fmax);
    // RL2 RL15 active gating
    assign active = (r.mode != M_OFF) && r.closed && r.run && !r.fault;
    assign tick   = (r.msdiv == 32'(P_CYC_PER_MS - 1));
    // margin comes from the live frequency; the division truncates,
    // so the captured band is never wider than 3 % either side
    // RL5 plus minus margin
    assign margin = (34'(i_freq_act) * 34'(MARGIN_PCT)) / 34'(PCT_DIV);
    assign cap_lo = i_freq_act - margin[31:0];
    assign cap_hi = i_freq_act + margin[31:0];
    // control writes decoded once for the checks below
    assign wr_ctrl = i_wr && (i_addr == A_CTRL);
    assign set_req = wr_ctrl && (i_wdata[1:0] == M_SET);

    // ************************************************************
    // next state
    // ************************************************************
    always_comb begin
        logic fault_set;
        logic capt_set;
        logic [1:0] clr;
        next_r = r;
        fault_set = 1'b0;
        capt_set = 1'b0;
        clr = 2'h0;
        // millisecond divider
        // tick pulses once per millisecond; it is the only slow rate
        next_r.msdiv = tick ? 32'h00000000 : r.msdiv + 32'h00000001;
        // RL14 restart on return
        if (!active || !oob) begin
            next_r.mscnt = 16'h0000;
        end else if (tick) begin
            // RL1 delay expiry
            if (r.mscnt + 16'h0001 >= r.dly) begin
                fault_set = 1'b1;
            end else begin
                next_r.mscnt = r.mscnt + 16'h0001;
            end
        end
        // register writes
        if (i_wr) begin
            case (i_addr)
                A_CTRL: begin
                    next_r.closed = i_wdata[B_CLOSED];
                    next_r.run = i_wdata[B_RUN];
                    if (i_wdata[1:0] == M_SET) begin
                        // RL5 RL6 capture only while running
                        if (i_wdata[B_RUN] && r.run) begin
                            next_r.fmin = cap_lo;
                            next_r.fmax = cap_hi;
                            next_r.mode = M_ON;
                            capt_set = 1'b1;
                        end
                    end else if (i_wdata[1:0] != 2'h3) begin
                        // the reserved code 3 never reaches this point
                        // RL4 off or on keeps limits
                        next_r.mode = i_wdata[1:0];
                    end
                end
                A_STAT: clr = i_wdata[1:0];
                A_MASK: next_r.mask = i_wdata[1:0];
                A_DLY: next_r.dly = i_wdata[15:0];
                // RL3 writable limits
                A_FMIN: next_r.fmin = i_wdata;
                A_FMAX: next_r.fmax = i_wdata;
                A_IOPOL: begin
                    next_r.ipol = i_wdata[3:0];
                    next_r.oinv = i_wdata[B_OINV +: 4];
                end
                A_OFSA: next_r.ofs_a = i_wdata[15:0];
                A_MULA: next_r.mul_a = i_wdata[15:0];
                A_OFSB: next_r.ofs_b = i_wdata[15:0];
                A_MULB: next_r.mul_b = i_wdata[15:0];
                // RL12 load resistor choice
                A_LOAD: next_r.load = i_wdata[1:0];
                default: ;
            endcase
        end
        // a clear that meets a new fault in the same cycle loses
        // RL7 sticky fault, set wins over clear
        next_r.fault = (r.fault & !clr[B_FAULT]) | fault_set;
        next_r.capt = (r.capt & !clr[B_CAPT]) | capt_set;
        // a new fault starts the next excursion count from zero
        if (fault_set) begin
            next_r.mscnt = 16'h0000;
        end
        // RL7 drive off on fault
        next_r.drive = next_r.run & !next_r.fault;
        // irq uses the next values so it moves together with the flags
        next_r.irq = |({next_r.capt, next_r.fault} & next_r.mask);
        // only the second synchroniser stage feeds any logic
        // RL8 input polarity after two-stage sync
        next_r.sync1 = i_din_pin;
        next_r.sync2 = r.sync1;
        next_r.din = r.sync2 ^ r.ipol;
        // RL9 output inversion
        next_r.dout = i_dout_func ^ r.oinv;
        // register reads
        // read data stand one cycle and are zero otherwise
        next_r.rdata = 32'h00000000;
        if (i_rd) begin
            case (i_addr)
                A_CTRL: next_r.rdata = {28'h0000000, r.run, r.closed,
                                        r.mode};
                A_STAT: next_r.rdata = {22'h000000, oob, active,
                                        6'h00, r.capt, r.fault};
                A_MASK: next_r.rdata = {30'h00000000, r.mask};
                A_DLY: next_r.rdata = {16'h0000, r.dly};
                A_FMIN: next_r.rdata = r.fmin;
                A_FMAX: next_r.rdata = r.fmax;
                A_FACT: next_r.rdata = i_freq_act;
                A_IOPOL: next_r.rdata = {20'h00000, r.oinv, 4'h0,
                                         r.ipol};
                A_OFSA: next_r.rdata = {16'h0000, r.ofs_a};
                A_MULA: next_r.rdata = {16'h0000, r.mul_a};
                A_OFSB: next_r.rdata = {16'h0000, r.ofs_b};
                A_MULB: next_r.rdata = {16'h0000, r.mul_b};
                A_LOAD: next_r.rdata = {30'h00000000, r.load};
                A_ARES: next_r.rdata = {4'h0, res_b, 4'h0, res_a};
                default: next_r.rdata = 32'h00000000;
            endcase
        end
    end

    // state register
    // synchronous reset returns every field to its default
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            r <= ST_RST;
        end else begin
            r <= next_r;
        end
    end

    // ************************************************************
    // analog scaling
    // ************************************************************
    // each input has its own offset and multiplier; the result is
    // registered inside the scaler, one cycle behind the code
    // RL10 RL11 per input scaler
    fm_scale u_scale_a (
        .i_clk   (i_clk),
        .i_reset (i_reset),
        .i_code  (i_analog_input_a),
        .i_ofs   (r.ofs_a),
        .i_mul   (r.mul_a),
        .o_res   (res_a)
    );

    fm_scale u_scale_b (
        .i_clk   (i_clk),
        .i_reset (i_reset),
        .i_code  (i_analog_input_b),
        .i_ofs   (r.ofs_b),
        .i_mul   (r.mul_b),
        .o_res   (res_b)
    );

    // ************************************************************
    // outputs
    // ************************************************************
    // every output is a state field or a registered scaler result
    assign o_rdata      = r.rdata;
    assign o_drive_en   = r.drive;
    assign o_freq_fault = r.fault;
    assign o_irq        = r.irq;
    assign o_din_func   = r.din;
    assign o_dout_pin   = r.dout;
    assign o_analog_a   = res_a;
    assign o_analog_b   = res_b;
    assign o_load_sel   = r.load;

    // ************************************************************
    // checks
    // ************************************************************
    default clocking dc @(posedge i_clk); endclocking
    default disable iff (i_reset);
    // checks watch the state struct, so they see what the next-state
    // logic really produced rather than what it was meant to

    // gating, timing, pin polarity and limits
    off_no_fault_a: assert property ( // RL15
        (r.mode == M_OFF && !r.fault) |=> !r.fault)
        else $error("fault raised with monitor off");
    open_loop_a: assert property (!r.closed |=> r.mscnt == 16'h0000) // RL2
        else $error("timer runs in open loop");
    drive_off_a: assert property (o_freq_fault |-> !o_drive_en) // RL7
        else $error("drive stays on during fault");
    timer_restart_a: assert property ( // RL14
        (active && !oob) |=> r.mscnt == 16'h0000)
        else $error("timer not restarted inside band");
    fault_delay_a: assert property ( // RL1
        (!r.fault ##1 r.fault) |-> $past(r.mscnt) + 16'h0001 >= r.dly)
        else $error("fault raised before delay expired");
    din_pol_a: assert property ( // RL8
        !$past(i_reset) |-> o_din_func == $past(r.sync2 ^ r.ipol))
        else $error("input polarity wrong");
    dout_inv_a: assert property ( // RL9
        !$past(i_reset) |-> o_dout_pin == $past(i_dout_func ^ r.oinv))
        else $error("output inversion wrong");
    capture_a: assert property ( // RL5
        (set_req && r.run && i_wdata[B_RUN])
        |=> r.fmin == $past(cap_lo) && r.fmax == $past(cap_hi))
        else $error("limit capture wrong");
    keep_limits_a: assert property ( // RL4
        (wr_ctrl && i_wdata[1:0] == M_ON && !r.run)
        |=> $stable(r.fmin) && $stable(r.fmax))
        else $error("limits changed when selecting on");
    mode_keep_a: assert property ( // RL4
        (wr_ctrl && i_wdata[1:0] == 2'h3) |=> $stable(r.mode))
        else $error("reserved mode code changed the mode");
    set_refused_a: assert property ( // RL4
        (set_req && !(r.run && i_wdata[B_RUN]))
        |=> $stable(r.fmin) && $stable(r.fmax))
        else $error("limits captured while stopped");
    capt_flag_a: assert property ( // RL5
        (set_req && r.run && i_wdata[B_RUN]) |=> r.capt && r.mode == M_ON)
        else $error("capture not flagged or mode not on");
    count_up_a: assert property ( // RL1
        (active && oob && tick && (r.mscnt + 16'h0001 < r.dly))
        |=> r.mscnt == $past(r.mscnt) + 16'h0001)
        else $error("delay timer did not advance on tick");

    // status, interrupt and drive
    fault_sticky_a: assert property ( // RL7
        (r.fault && !(i_wr && i_addr == A_STAT && i_wdata[B_FAULT]))
        |=> r.fault)
        else $error("fault cleared without a status write");
    irq_level_a: assert property ( // RL7
        o_irq == |({r.capt, r.fault} & r.mask))
        else $error("interrupt does not follow unmasked status");
    drive_run_a: assert property ( // RL7
        (r.run && !r.fault) |-> o_drive_en)
        else $error("drive off while running without fault");
endmodule // fm_monitor

// File: sim/fm_plant.sv
// Purpose: conveyor drive stand-in reporting the running frequency
// Assumes: frequency in 0.1 mHz units, same clock as the monitor
// Notes:   a stopped drive reads as zero frequency
`timescale 1ns/100ps
module fm_plant (
    // clock and reset
    input  wire logic        i_clk,
    input  wire logic        i_reset,
    // command and drive
    input  wire logic [31:0] i_freq_set,
    input  wire logic        i_drive_en,
    // measured frequency
    output logic [31:0]      o_freq_act
);
    // ************************************************************
    // measured frequency
    // ************************************************************
    // off drive stands
    always_ff @(posedge i_clk) begin
        if (i_reset || !i_drive_en) begin
            o_freq_act <= 32'h00000000;
        end else begin
            o_freq_act <= i_freq_set;   // magnet swings at commanded rate
        end
    end
endmodule // fm_plant

// File: sim/tb_top.sv
// Purpose: self-checking bench of the frequency monitor block
// Assumes: tick shortened to 10 cycles, delay written as 3 ms
// Notes:   registers reached through the plain strobe port
`timescale 1ns/100ps
module tb_top;
    import fm_pkg::*;
    logic        i_clk, i_reset, i_wr, i_rd, o_drive_en, o_freq_fault, o_irq;
    logic [7:0]  i_addr;
    logic [31:0] i_wdata, o_rdata, freq_set, freq_act;
    logic [3:0]  i_din_pin, o_din_func, i_dout_func, o_dout_pin;
    logic [11:0] ana_a, ana_b, o_analog_a, o_analog_b;
    logic [1:0]  o_load_sel;
    int          bad_count, checks_done, cycles, n;
    localparam logic [31:0] F_IN  = 32'h000F4240; // 100 Hz
    localparam logic [31:0] F_OUT = 32'h003D0900; // 400 Hz
    localparam logic [31:0] ALL   = 32'hFFFFFFFF; // compare every bit

    fm_monitor #(.P_CYC_PER_MS(10)) u_fm_monitor (
        .i_clk(i_clk), .i_reset(i_reset), .i_addr(i_addr),
        .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
        .i_freq_act(freq_act), .o_drive_en(o_drive_en),
        .o_freq_fault(o_freq_fault), .o_irq(o_irq),
        .i_din_pin(i_din_pin), .o_din_func(o_din_func),
        .i_dout_func(i_dout_func), .o_dout_pin(o_dout_pin),
        .i_analog_input_a(ana_a), .i_analog_input_b(ana_b),
        .o_analog_a(o_analog_a), .o_analog_b(o_analog_b),
        .o_load_sel(o_load_sel));
    fm_plant u_fm_plant (
        .i_clk(i_clk), .i_reset(i_reset), .i_freq_set(freq_set),
        .i_drive_en(o_drive_en), .o_freq_act(freq_act));

    // ************************************************************
    // clock, timeout and shared tasks
    // ************************************************************
    initial begin
        i_clk = 1'b0;
        forever #5 i_clk = ~i_clk;
    end
    // cut a hang short
    always @(posedge i_clk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            bad_count++;
            conclude();
        end
    end
    task automatic chk(input string nm, input logic [31:0] got, exp);
        checks_done++;
        if (got !== exp) begin
            bad_count++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic waitc(input int k);
        repeat (k) @(posedge i_clk);
        #1;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge i_clk);
        i_wr <= 1'b1;
        i_addr <= a;
        i_wdata <= d;
        @(posedge i_clk);
        i_wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge i_clk);
        i_rd <= 1'b1;
        i_addr <= a;
        @(posedge i_clk);
        i_rd <= 1'b0;
        #1 d = o_rdata;             // data stand only this cycle
    endtask
    task automatic rchk(input string nm, input logic [7:0] a,
                        input logic [31:0] m, exp);
        logic [31:0] d;
        rd(a, d);
        chk(nm, d & m, exp);
    endtask
    task automatic conclude();
        $display("checks %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // ************************************************************
    // main sequence
    // ************************************************************
    initial begin
        {i_wr, i_rd, i_addr, i_wdata} = '0;
        {i_din_pin, i_dout_func, ana_a, ana_b} = '0;
        i_reset = 1'b1;
        freq_set = F_IN;
        bad_count = 0;
        checks_done = 0;
        repeat (8) @(posedge i_clk);
        i_reset <= 1'b0;
        // reset values
        rchk("delay", A_DLY, ALL, 32'h0000EA60);
        rchk("fmin", A_FMIN, ALL, 32'h0000755B);
        rchk("fmax", A_FMAX, ALL, 32'h002DC6C0);
        // pin polarity, default then flipped
        i_din_pin <= 4'hA;
        i_dout_func <= 4'h3;
        waitc(4);
        chk("din", {28'h0, o_din_func}, 32'h0000000A);
        chk("dout", {28'h0, o_dout_pin}, 32'h00000003);
        wr(A_IOPOL, 32'h00000C0F);
        waitc(4);
        chk("din", {28'h0, o_din_func}, 32'h00000005);
        chk("dout", {28'h0, o_dout_pin}, 32'h0000000F);
        // analog offset before multiplier, clamps, load choice
        wr(A_OFSA, 32'h00000064);
        wr(A_MULA, 32'h00002000);
        ana_a <= 12'h3E8;
        waitc(3);
        chk("ana_a", {20'h0, o_analog_a}, 32'h00000898);
        ana_a <= 12'hBB8;
        wr(A_OFSB, 32'h0000FE0C);
        ana_b <= 12'h064;
        waitc(3);
        chk("ana_a", {20'h0, o_analog_a}, 32'h00000FFF);
        chk("ana_b", {20'h0, o_analog_b}, 32'h00000000);
        wr(A_OFSB, 32'h00000000);
        wr(A_MULB, 32'h00000948);   // 0.58 from 20 g over 10 V
        ana_b <= 12'h3E8;
        waitc(3);
        rchk("ares", A_ARES, ALL, 32'h02440FFF);
        wr(A_LOAD, 32'h00000002);
        waitc(2);
        chk("load", {30'h0, o_load_sel}, 32'h00000002);
        // supervision idle in open loop and when off
        wr(A_DLY, 32'h00000003);
        freq_set <= F_OUT;
        wr(A_CTRL, 32'h00000009);
        waitc(60);
        chk("fault", {31'h0, o_freq_fault}, 32'h0);
        wr(A_CTRL, 32'h0000000C);
        waitc(60);
        chk("fault", {31'h0, o_freq_fault}, 32'h0);
        // short excursions restart the delay
        freq_set <= F_IN;
        wr(A_CTRL, 32'h0000000D);
        freq_set <= F_OUT;
        waitc(15);
        freq_set <= F_IN;
        waitc(20);
        freq_set <= F_OUT;
        waitc(15);
        freq_set <= F_IN;
        waitc(5);
        chk("fault", {31'h0, o_freq_fault}, 32'h0);
        // lasting excursion faults after the delay
        freq_set <= F_OUT;
        n = 0;
        while (o_freq_fault !== 1'b1 && n < 60) begin
            waitc(1);
            n++;
        end
        chk("delay_win", {31'h0, n >= 20 && n <= 34}, 32'h1);
        chk("drive", {31'h0, o_drive_en}, 32'h0);
        rchk("stat", A_STAT, 32'h3, 32'h1);
        chk("irq", {31'h0, o_irq}, 32'h0);
        wr(A_MASK, 32'h00000001);
        waitc(2);
        chk("irq", {31'h0, o_irq}, 32'h1);
        freq_set <= F_IN;
        wr(A_STAT, 32'h00000001);
        waitc(3);
        chk("irq", {31'h0, o_irq}, 32'h0);
        chk("drive", {31'h0, o_drive_en}, 32'h1);
        // capture while running at 100 Hz
        waitc(3);
        wr(A_CTRL, 32'h0000000E);   // run already on
        rchk("fmin", A_FMIN, ALL, 32'h000ECD10);
        rchk("fmax", A_FMAX, ALL, 32'h000FB770);
        rchk("mode", A_CTRL, 32'h3, 32'h1);
        rchk("capt", A_STAT, 32'h2, 32'h2);
        // stopped: set refused, on keeps limits
        wr(A_CTRL, 32'h00000006);
        wr(A_CTRL, 32'h00000005);
        rchk("fmin", A_FMIN, ALL, 32'h000ECD10);
        rchk("ctrl", A_CTRL, ALL, 32'h00000005);
        // reserved mode code leaves the mode at on
        wr(A_CTRL, 32'h00000007);
        rchk("mode3", A_CTRL, ALL, 32'h00000005);
        wr(A_FMIN, 32'h00001234);
        rchk("fmin", A_FMIN, ALL, 32'h00001234);
        rchk("unmapped", 8'hF0, ALL, 32'h0);
        conclude();
    end
endmodule // tb_top
